/* hdl/spb_msg_handler.sv */
// Streamed playback message handler: parser, playback and replies
`timescale 1ns/1ns
`default_nettype none
// Function
// - mute request answered by 6-byte ack id 000D, zero or error result.
// - output-halted notice is 4 bytes, id 007C, no payload.
// - decoding starts on its own after first data block completes.
// - output waits for 256 decoded samples (16 ms), then begins.
// - second stop request ends stream, clears buffer, normally no notice.
// - halted notice may follow stop ack on coincident underrun or end.
// - device detects stream end, notices after all audio is output.
// - after normal end, two stop exchanges are accepted without fault.
// - hold request gives halted notice once output has stopped.
// - hold request cancelling pause restarts output.
// - buffer-space notice sent when buffer has room for next block.
// - decoder setup 0x10 bytes, id 006B, format 09, rate bytes 8-11.
// - decoder setup ack 6 bytes, id 006C, zero or error result.
// - every data block acked with 6 bytes, id 006E, result.
// - buffer notice 0x11 bytes, id 006F, reserved bytes zero.
// - hold request 8 bytes, id 0070, flag 1 pauses, 0 cancels.
// - stop request 6 bytes, id 0072; the second one ends playback, empties buffer.
// - stop ack 0x14 bytes, id 0073, result, reserved zero.
module spb_msg_handler
	import spb_pkg::*;
#(
	parameter int BUF_BYTES = 4096
)
(
	input  wire logic   i_clk,
	input  wire logic   i_sys_rst,
	input  wire logic   i_rx_valid,
	input  wire logic [7:0] i_rx_byte,
	input  wire logic   i_tx_ready,
	input  wire logic   i_dec_tick,
	input  wire logic   i_out_tick,
	output logic        o_tx_valid,
	output logic [7:0]  o_tx_byte,
	output logic        o_blk_valid,
	output logic [7:0]  o_blk_byte,
	output logic [31:0] o_sample_rate,
	output logic        o_decoding,
	output logic        o_output_on,
	output logic        o_muted
);
	localparam int LW = $clog2(BUF_BYTES + 1);

	spb_tx_if u_if ();

	spb_state_t  st_q, st_d;
	logic [15:0] idx_q, idx_d, len_q, len_d, id_q, id_d, id_now, pay;
	logic [15:0] bsz_q, bsz_d, aid_q, aid_d, alen_q, alen_d, ares_q;
	logic [15:0] ares_d, tid_q, tid_d, tlen_q, tlen_d, tres_q, tres_d;
	logic [31:0] rate_q, rate_d, orate_q, orate_d;
	logic [LW-1:0]    lvl_q, lvl_d;
	logic [DEC_W-1:0] dec_q, dec_d;
	logic bad_q, bad_d, flg_q, flg_d, bv_q, bv_d, eom, ok, room, short;
	logic [7:0] bb_q, bb_d;
	logic hold_q, hold_d, mute_q, mute_d, stop1_q, stop1_d, fin_q, fin_d;
	logic ack_q, ack_d, halt_q, halt_d, spc_q, spc_d, go_q, go_d;
	logic run_q, run_d, on_q, on_d;

	// ==========================================
	// Inbound parser
	always_comb
	begin
		idx_d  = idx_q;
		len_d  = len_q;
		id_d   = id_q;
		bad_d  = bad_q;
		flg_d  = flg_q;
		rate_d = rate_q;
		bv_d   = 1'b0;
		bb_d   = i_rx_byte;
		eom    = 1'b0;
		id_now = id_q;
		if (i_rx_valid)
		begin
			idx_d = idx_q + 16'h0001;
			// length and id low byte first
			if (idx_q == 16'h0000)
			begin
				len_d = {8'h00, i_rx_byte};
				bad_d = 1'b0;
			end
			if (idx_q == 16'h0001)
				len_d[15:8] = i_rx_byte;
			if (idx_q == 16'h0002)
				id_d[7:0] = i_rx_byte;
			if (idx_q == 16'h0003)
			begin
				id_d[15:8] = i_rx_byte;
				id_now = id_d;
			end
			if (idx_q >= OFS_FLAG)
			begin
				if (id_q == ID_DEC_SETUP)
				begin
					if (idx_q == OFS_FMT)
						bad_d = bad_d | (i_rx_byte != FMT_CODE);
					else if (idx_q >= OFS_RATE0 && idx_q <= OFS_RATE3)
						rate_d = {i_rx_byte, rate_q[31:8]};
					else
						bad_d = bad_d | (i_rx_byte != 8'h00);
				end
				// flag must be 0 or 1
				else if (id_q == ID_HOLD_REQ || id_q == ID_MUTE_REQ)
				begin
					if (idx_q == OFS_FLAG)
						flg_d = i_rx_byte[0];
					bad_d = bad_d | ((idx_q == OFS_FLAG) ?
						(i_rx_byte > 8'h01) : (i_rx_byte != 8'h00));
				end
				else if (id_q == ID_STOP_REQ)
					bad_d = bad_d | (i_rx_byte != 8'h00);
				else if (id_q == ID_BLK_REQ)
				begin
					if (idx_q < BLK_HDR)
						bad_d = bad_d | (i_rx_byte != 8'h00);
					else
						bv_d = 1'b1;
				end
			end
			if (idx_q >= 16'h0003 && idx_d >= len_q)
			begin
				eom   = 1'b1;
				idx_d = 16'h0000;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			idx_q  <= 16'h0000;
			len_q  <= 16'h0000;
			id_q   <= 16'h0000;
			bad_q  <= 1'b0;
			flg_q  <= 1'b0;
			rate_q <= 32'h0000_0000;
			bv_q   <= 1'b0;
			bb_q   <= 8'h00;
		end
		else
		begin
			idx_q  <= idx_d;
			len_q  <= len_d;
			id_q   <= id_d;
			bad_q  <= bad_d;
			flg_q  <= flg_d;
			rate_q <= rate_d;
			bv_q   <= bv_d;
			bb_q   <= bb_d;
		end
	end

	// ==========================================
	// Playback state, replies and launch
	assign pay   = len_q - BLK_HDR;
	assign short = pay != 16'h0000 &&
		pay < ((bsz_q == 16'h0000) ? BLK_SZ_S : bsz_q);
	assign room  = int'(lvl_q) + int'(bsz_q) <= BUF_BYTES;

	always_comb
	begin
		st_d = st_q; lvl_d = lvl_q; dec_d = dec_q; bsz_d = bsz_q;
		hold_d = hold_q; mute_d = mute_q; stop1_d = stop1_q;
		fin_d = fin_q; ack_d = ack_q; halt_d = halt_q; spc_d = spc_q;
		aid_d = aid_q; alen_d = alen_q; ares_d = ares_q; orate_d = orate_q;
		tid_d = tid_q; tlen_d = tlen_q; tres_d = tres_q; go_d = 1'b0;
		ok = !bad_d;
		if (!u_if.busy && !go_q)
		begin
			if (ack_q)
			begin
				go_d = 1'b1; ack_d = 1'b0;
				tid_d = aid_q; tlen_d = alen_q; tres_d = ares_q;
			end
			else if (halt_q)
			begin
				go_d = 1'b1; halt_d = 1'b0;
				tid_d = ID_HALTED; tlen_d = LEN_HALTED; tres_d = RES_OK;
			end
			else if (spc_q && room)
			begin
				go_d = 1'b1; spc_d = 1'b0;
				tid_d = ID_SPACE; tlen_d = LEN_SPACE; tres_d = RES_OK;
			end
		end
		// Decoder drains one buffer byte per sample
		if ((st_q == SPB_FILL || st_q == SPB_PLAY || st_q == SPB_HOLD)
			&& i_dec_tick && lvl_q != '0 && dec_q != DEC_MAX)
		begin
			lvl_d = lvl_q - LW'(1);
			dec_d = dec_q + DEC_W'(1);
		end
		if (bv_d && st_q != SPB_IDLE && st_q != SPB_DONE
			&& int'(lvl_d) < BUF_BYTES)
			lvl_d = lvl_d + LW'(1);
		if (st_q == SPB_PLAY && i_out_tick && dec_q != '0)
			dec_d = dec_d - DEC_W'(1);
		unique case (st_q)
			SPB_IDLE, SPB_SETUP, SPB_DONE: ;
			SPB_FILL:
				if (dec_q >= START_SAMPLES && !hold_q)
					st_d = SPB_PLAY;
			SPB_PLAY:
				if (hold_q)
				begin
					st_d = SPB_HOLD;
					halt_d = 1'b1;
				end
				else if (dec_q == '0 && lvl_q == '0)
				begin
					halt_d = 1'b1;
					st_d = fin_q ? SPB_DONE : SPB_FILL;
				end
			SPB_HOLD:
				if (!hold_q)
					st_d = SPB_PLAY;
		endcase
		if (eom)
		begin
			ack_d = 1'b1; stop1_d = 1'b0; alen_d = LEN_ACK;
			case (id_now)
				ID_OUT_SETUP:
				begin
					ok = ok && len_q == LEN_OUT_SETUP;
					aid_d = ID_OUT_SETUP_ACK;
				end
				ID_MUTE_REQ:
				begin
					ok = ok && len_q == LEN_SHORT_REQ;
					aid_d = ID_MUTE_ACK;
					if (ok)
						mute_d = flg_d;
				end
				ID_DEC_SETUP:
				begin
					ok = ok && len_q == LEN_DEC_SETUP &&
						(st_q == SPB_IDLE || st_q == SPB_SETUP);
					aid_d = ID_DEC_ACK;
					if (ok)
					begin
						st_d = SPB_SETUP;
						orate_d = rate_d;
					end
				end
				ID_BLK_REQ:
				begin
					ok = ok && st_q != SPB_IDLE && st_q != SPB_DONE && !fin_q
						&& (short || ((pay == BLK_SZ_S || pay == BLK_SZ_M ||
						pay == BLK_SZ_L) && (bsz_q == '0 || pay == bsz_q)));
					aid_d = ID_BLK_ACK;
					if (ok)
					begin
						spc_d = 1'b1;
						fin_d = short;
						if (bsz_q == '0)
							bsz_d = short ? BLK_SZ_S : pay;
						if (st_q == SPB_SETUP)
							st_d = SPB_FILL;
					end
				end
				ID_HOLD_REQ:
				begin
					ok = ok && len_q == LEN_HOLD_REQ;
					aid_d = ID_HOLD_ACK;
					if (ok)
						hold_d = flg_d;
				end
				ID_STOP_REQ:
				begin
					ok = ok && len_q == LEN_SHORT_REQ;
					aid_d = ID_STOP_ACK;
					alen_d = LEN_STOP_ACK;
					if (ok && stop1_q)
					begin
						st_d = SPB_IDLE; lvl_d = '0; dec_d = '0;
						bsz_d = '0; fin_d = 1'b0; hold_d = 1'b0;
						mute_d = 1'b0; spc_d = 1'b0;
					end
					else if (ok)
						stop1_d = 1'b1;
				end
				default:
					ack_d = ack_q;
			endcase
			ares_d = ok ? RES_OK : RES_BAD;
		end
		run_d = st_d == SPB_FILL || st_d == SPB_PLAY || st_d == SPB_HOLD;
		on_d = st_d == SPB_PLAY;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_q <= SPB_IDLE; lvl_q <= '0; dec_q <= '0; bsz_q <= '0;
			hold_q <= 1'b0; mute_q <= 1'b0; stop1_q <= 1'b0; fin_q <= 1'b0;
			ack_q <= 1'b0; halt_q <= 1'b0; spc_q <= 1'b0; go_q <= 1'b0;
			aid_q <= '0; alen_q <= '0; ares_q <= '0; orate_q <= '0;
			tid_q <= '0; tlen_q <= '0; tres_q <= '0;
			run_q <= 1'b0; on_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d; lvl_q <= lvl_d; dec_q <= dec_d; bsz_q <= bsz_d;
			hold_q <= hold_d; mute_q <= mute_d; stop1_q <= stop1_d;
			fin_q <= fin_d; ack_q <= ack_d; halt_q <= halt_d;
			spc_q <= spc_d; go_q <= go_d; aid_q <= aid_d; alen_q <= alen_d;
			ares_q <= ares_d; orate_q <= orate_d; tid_q <= tid_d;
			tlen_q <= tlen_d; tres_q <= tres_d; run_q <= run_d; on_q <= on_d;
		end
	end

	assign u_if.start = go_q;
	assign u_if.id    = tid_q;
	assign u_if.len   = tlen_q;
	assign u_if.res   = tres_q;

	spb_tx_ser u_tx (
		.i_clk      (i_clk),
		.i_sys_rst  (i_sys_rst),
		.tx         (u_if.tx),
		.i_tx_ready (i_tx_ready),
		.o_tx_valid (o_tx_valid),
		.o_tx_byte  (o_tx_byte)
	);

	assign o_blk_valid   = bv_q;
	assign o_blk_byte    = bb_q;
	assign o_sample_rate = orate_q;
	assign o_decoding    = run_q;
	assign o_output_on   = on_q;
	assign o_muted       = mute_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_fill_play;
		st_q == SPB_FILL ##1 st_q == SPB_PLAY;
	endsequence
	sequence s_play_hold;
		st_q == SPB_PLAY ##1 st_q == SPB_HOLD;
	endsequence
	AST_MUTE_ACK: assert property (
		eom && id_now == ID_MUTE_REQ |=> ack_q && aid_q == ID_MUTE_ACK)
		else $error("mute request not acked");
	AST_FIRST_BLK: assert property (
		eom && id_now == ID_BLK_REQ && ok && st_q == SPB_SETUP
		|=> st_q == SPB_FILL && o_decoding)
		else $error("decoding did not start");
	AST_START_256: assert property (
		s_fill_play |-> $past(dec_q) >= START_SAMPLES)
		else $error("output began before 256 samples");
	AST_STOP_TWICE: assert property (
		eom && id_now == ID_STOP_REQ && ok && stop1_q
		|=> st_q == SPB_IDLE && lvl_q == '0 && dec_q == '0)
		else $error("second stop did not clear stream");
	AST_STOP_ONCE: assert property (
		eom && id_now == ID_STOP_REQ && !stop1_q && st_q == SPB_PLAY
		|=> st_q != SPB_IDLE && stop1_q)
		else $error("single stop ended stream");
	AST_END_HALT: assert property (
		st_q == SPB_PLAY ##1 st_q == SPB_DONE |-> halt_q || go_q)
		else $error("end without halted notice");
	AST_HOLD_HALT: assert property (
		s_play_hold |-> halt_q || (go_q && tid_q == ID_HALTED))
		else $error("pause without halted notice");
	AST_RESUME: assert property (
		st_q == SPB_HOLD && !hold_q |=> st_q == SPB_PLAY ##1 o_output_on)
		else $error("cancel did not restart output");
	AST_SPACE: assert property (
		eom && id_now == ID_BLK_REQ && ok |=> spc_q)
		else $error("no buffer notice pending after block");
	AST_BLK_ACK: assert property (
		eom && id_now == ID_BLK_REQ |=> ack_q && aid_q == ID_BLK_ACK
		&& alen_q == LEN_ACK)
		else $error("data block not acked");
endmodule
`default_nettype wire

/* shared/spb_pkg.sv */
// Constants and types for the streamed playback message handler
`default_nettype none
package spb_pkg;
	// ==========================================
	// Message identifiers
	localparam logic [15:0] ID_OUT_SETUP     = 16'h0008;
	localparam logic [15:0] ID_OUT_SETUP_ACK = 16'h0009;
	localparam logic [15:0] ID_MUTE_REQ      = 16'h000C;
	localparam logic [15:0] ID_MUTE_ACK      = 16'h000D;
	localparam logic [15:0] ID_DEC_SETUP     = 16'h006B;
	localparam logic [15:0] ID_DEC_ACK       = 16'h006C;
	localparam logic [15:0] ID_BLK_REQ       = 16'h006D;
	localparam logic [15:0] ID_BLK_ACK       = 16'h006E;
	localparam logic [15:0] ID_SPACE         = 16'h006F;
	localparam logic [15:0] ID_HOLD_REQ      = 16'h0070;
	localparam logic [15:0] ID_HOLD_ACK      = 16'h0071;
	localparam logic [15:0] ID_STOP_REQ      = 16'h0072;
	localparam logic [15:0] ID_STOP_ACK      = 16'h0073;
	localparam logic [15:0] ID_HALTED        = 16'h007C;
	// ==========================================
	// Message lengths in bytes
	localparam logic [15:0] LEN_ACK       = 16'h0006;
	localparam logic [15:0] LEN_HALTED    = 16'h0004;
	localparam logic [15:0] LEN_SPACE     = 16'h0011;
	localparam logic [15:0] LEN_STOP_ACK  = 16'h0014;
	localparam logic [15:0] LEN_OUT_SETUP = 16'h000C;
	localparam logic [15:0] LEN_DEC_SETUP = 16'h0010;
	localparam logic [15:0] LEN_HOLD_REQ  = 16'h0008;
	localparam logic [15:0] LEN_SHORT_REQ = 16'h0006;
	// ==========================================
	// Field positions and values
	localparam logic [15:0] OFS_FLAG  = 16'h0004;
	localparam logic [15:0] OFS_FMT   = 16'h0005;
	localparam logic [15:0] OFS_RATE0 = 16'h0008;
	localparam logic [15:0] OFS_RATE3 = 16'h000B;
	localparam logic [15:0] BLK_HDR   = 16'h0008;
	localparam logic [7:0]  FMT_CODE  = 8'h09;
	localparam logic [15:0] BLK_SZ_S  = 16'h0200;
	localparam logic [15:0] BLK_SZ_M  = 16'h0400;
	localparam logic [15:0] BLK_SZ_L  = 16'h0800;
	localparam logic [15:0] RES_OK    = 16'h0000;
	localparam logic [15:0] RES_BAD   = 16'h0001;
	// ==========================================
	// Playback: 256 samples, 16 ms at 16 kHz
	localparam int          DEC_W         = 12;
	localparam logic [11:0] START_SAMPLES = 12'h100;
	localparam logic [11:0] DEC_MAX       = 12'hFFF;
	typedef enum logic [2:0] {
		SPB_IDLE  = 3'b000,
		SPB_SETUP = 3'b001,
		SPB_FILL  = 3'b010,
		SPB_PLAY  = 3'b011,
		SPB_HOLD  = 3'b100,
		SPB_DONE  = 3'b101
	} spb_state_t;
endpackage
`default_nettype wire

/* shared/spb_tx_if.sv */
// Message launch carrier between handler and serializer
`timescale 1ns/1ns
`default_nettype none
interface spb_tx_if;
	logic        start;
	logic [15:0] id;
	logic [15:0] len;
	logic [15:0] res;
	logic        busy;
	modport main (output start, output id, output len, output res,
		input busy);
	modport tx (input start, input id, input len, input res,
		output busy);
endinterface
`default_nettype wire

/* hdl/spb_tx_ser.sv */
// Outbound message serializer
`timescale 1ns/1ns
`default_nettype none
module spb_tx_ser
	import spb_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_sys_rst,
	spb_tx_if.tx       tx,
	input  wire logic  i_tx_ready,
	output logic       o_tx_valid,
	output logic [7:0] o_tx_byte
);
	logic [15:0] idx_q, idx_d, len_q, len_d, id_q, id_d, res_q, res_d;
	logic        vld_q, vld_d;
	logic [7:0]  byt_q, byt_d;

	function automatic logic [7:0] pick(input logic [15:0] i, l, d, r);
		case (i)
			16'h0000: pick = l[7:0];
			16'h0001: pick = l[15:8];
			16'h0002: pick = d[7:0];
			16'h0003: pick = d[15:8];
			16'h0004: pick = r[7:0];
			16'h0005: pick = r[15:8];
			default:  pick = 8'h00;
		endcase
	endfunction

	// ==========================================
	// Byte sequencing
	always_comb
	begin
		idx_d = idx_q;
		len_d = len_q;
		id_d  = id_q;
		res_d = res_q;
		vld_d = vld_q;
		byt_d = byt_q;
		if (tx.start)
		begin
			len_d = tx.len;
			id_d  = tx.id;
			res_d = tx.res;
			idx_d = 16'h0000;
			vld_d = 1'b1;
			byt_d = tx.len[7:0];
		end
		else if (vld_q && i_tx_ready)
		begin
			idx_d = idx_q + 16'h0001;
			if (idx_d >= len_q)
				vld_d = 1'b0;
			else
				byt_d = pick(idx_d, len_q, id_q, res_q);
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			idx_q <= 16'h0000;
			len_q <= 16'h0000;
			id_q  <= 16'h0000;
			res_q <= 16'h0000;
			vld_q <= 1'b0;
			byt_q <= 8'h00;
		end
		else
		begin
			idx_q <= idx_d;
			len_q <= len_d;
			id_q  <= id_d;
			res_q <= res_d;
			vld_q <= vld_d;
			byt_q <= byt_d;
		end
	end

	assign tx.busy    = vld_q;
	assign o_tx_valid = vld_q;
	assign o_tx_byte  = byt_q;

	// ==========================================
	// Checks
	AST_TX_HDR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx.start |=> o_tx_valid && o_tx_byte == $past(tx.len[7:0]))
		else $error("first byte is not length low byte");
	AST_HALT_LEN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx.start && tx.id == ID_HALTED |-> tx.len == LEN_HALTED)
		else $error("halted notice length wrong");
endmodule
`default_nettype wire

/* dv/spb_host_model.sv */
// Host partner model: frames requests and collects device replies
`timescale 1ns/1ns
`default_nettype none
module spb_host_model
	import spb_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_byte,
	input  wire logic       i_slow,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_byte,
	output logic            o_tx_ready
);
	logic [7:0]  rbuf [0:31];
	logic [15:0] q_id [$];
	logic [15:0] q_len [$];
	logic [15:0] q_res [$];
	int          idx;
	int          bad_rsv;

	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h00;
		o_tx_ready = 1'b1;
		bad_rsv = 0;
	end

	// ==========================================
	// Reply side, stalls every other cycle when slow
	always @(negedge i_clk)
		o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;

	always @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
			idx = 0;
		else if (i_tx_valid && o_tx_ready)
		begin
			if (idx < 32)
				rbuf[idx] = i_tx_byte;
			idx++;
			if (idx > 3 && idx == {rbuf[1], rbuf[0]})
			begin
				q_len.push_back({rbuf[1], rbuf[0]});
				q_id.push_back({rbuf[3], rbuf[2]});
				q_res.push_back(idx > 5 ? {rbuf[5], rbuf[4]} : 16'h0000);
				for (int i = 6; i < idx && i < 32; i++)
					if (rbuf[i] !== 8'h00)
						bad_rsv++;
				idx = 0;
			end
		end

	// ==========================================
	// Request side
	// request framing
	task automatic send_msg(input logic [15:0] len, input logic [15:0] id,
		input logic [15:0] w45, input logic [31:0] rate);
		logic [7:0] b;
		for (int i = 0; i < len; i++)
		begin
			case (i)
				0: b = len[7:0];
				1: b = len[15:8];
				2: b = id[7:0];
				3: b = id[15:8];
				4: b = w45[7:0];
				5: b = w45[15:8];
				default:
					if (id == ID_DEC_SETUP && i >= 8 && i < 12)
						b = rate[8*(i-8) +: 8];
					else if (id == ID_BLK_REQ && i >= 8)
						b = 8'(i) ^ 8'h5A;
					else
						b = 8'h00;
			endcase
			@(negedge i_clk);
			o_rx_valid = 1'b1;
			o_rx_byte = b;
		end
		@(negedge i_clk);
		o_rx_valid = 1'b0;
		o_rx_byte = ~b;
	endtask
endmodule
`default_nettype wire

/* dv/spb_msg_handler_tb_top.sv */
// Self-checking testbench for the streamed playback message handler
`timescale 1ns/1ns
`default_nettype none
module spb_msg_handler_tb_top;
	import spb_pkg::*;
	logic        clk;
	logic        rst;
	logic        rx_valid;
	logic [7:0]  rx_byte;
	logic        tx_ready;
	logic        dec_tick;
	logic        out_tick;
	logic        slow;
	logic        tx_valid;
	logic [7:0]  tx_byte;
	logic        blk_valid;
	logic [7:0]  blk_byte;
	logic [31:0] rate;
	logic        decoding;
	logic        output_on;
	logic        muted;
	int          failures;
	int          total_checks;
	int          cycles;
	int          blk_cnt;

	spb_msg_handler #(.BUF_BYTES(2048)) DUT (
		.i_clk(clk), .i_sys_rst(rst), .i_rx_valid(rx_valid),
		.i_rx_byte(rx_byte), .i_tx_ready(tx_ready), .i_dec_tick(dec_tick),
		.i_out_tick(out_tick), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
		.o_blk_valid(blk_valid), .o_blk_byte(blk_byte), .o_sample_rate(rate),
		.o_decoding(decoding), .o_output_on(output_on), .o_muted(muted)
	);

	spb_host_model HOST (
		.i_clk(clk), .i_sys_rst(rst), .i_tx_valid(tx_valid),
		.i_tx_byte(tx_byte), .i_slow(slow), .o_rx_valid(rx_valid),
		.o_rx_byte(rx_byte), .o_tx_ready(tx_ready)
	);

	initial
		clk = 1'b0;
	always #25 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			complete_run();
		end
	end

	// payload bytes pass through in order
	always @(negedge clk)
		if (blk_valid)
		begin
			check(blk_byte, 8'(blk_cnt + 8) ^ 8'h5A);
			blk_cnt++;
		end

	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic expect_msg(input logic [15:0] len, id, res);
		int n;
		n = 0;
		while (HOST.q_id.size() == 0 && n < 4000)
		begin
			@(negedge clk);
			n++;
		end
		if (HOST.q_id.size() == 0)
			check(32'h0000_0000, {16'h0001, id});
		else
		begin
			check(HOST.q_len.pop_front(), len);
			check(HOST.q_id.pop_front(), id);
			check(HOST.q_res.pop_front(), res);
		end
	endtask

	task automatic ticks(input int nd, input int no);
		for (int i = 0; i < nd + no; i++)
		begin
			@(negedge clk);
			dec_tick = i < nd;
			out_tick = i >= nd;
		end
		@(negedge clk);
		dec_tick = 1'b0;
		out_tick = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic start_stream(input logic [31:0] r, input logic [15:0] sz);
		HOST.send_msg(LEN_DEC_SETUP, ID_DEC_SETUP, 16'h0900, r);
		expect_msg(LEN_ACK, ID_DEC_ACK, RES_OK);
		check(rate, r);
		blk_cnt = 0;
		HOST.send_msg(BLK_HDR + sz, ID_BLK_REQ, 16'h0000, 0);
		expect_msg(LEN_ACK, ID_BLK_ACK, RES_OK);
		expect_msg(LEN_SPACE, ID_SPACE, RES_OK);
		check(blk_cnt, sz);
		check(decoding, 1'b1);
		ticks(255, 0);
		check(output_on, 1'b0);
		ticks(1, 0);
		check(output_on, 1'b1);
	endtask

	task automatic stop_pair(input logic run);
		HOST.send_msg(LEN_SHORT_REQ, ID_STOP_REQ, 16'h0000, 0);
		expect_msg(LEN_STOP_ACK, ID_STOP_ACK, RES_OK);
		check(decoding, run);
		HOST.send_msg(LEN_SHORT_REQ, ID_STOP_REQ, 16'h0000, 0);
		expect_msg(LEN_STOP_ACK, ID_STOP_ACK, RES_OK);
		repeat (60) @(negedge clk);
		check({decoding, output_on, muted}, 3'h0);
		check(HOST.q_id.size(), 0);
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================
	// Test sequence
	initial
	begin
		rst = 1'b1;
		dec_tick = 1'b0;
		out_tick = 1'b0;
		slow = 1'b0;
		failures = 0;
		total_checks = 0;
		cycles = 0;
		blk_cnt = 0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check({tx_valid, decoding, output_on, muted}, 4'h0);
		HOST.send_msg(LEN_OUT_SETUP, ID_OUT_SETUP, 16'h3100, 0);
		expect_msg(LEN_ACK, ID_OUT_SETUP_ACK, RES_OK);
		HOST.send_msg(LEN_DEC_SETUP, ID_DEC_SETUP, 16'h0500, 32'h3E80);
		expect_msg(LEN_ACK, ID_DEC_ACK, RES_BAD);
		start_stream(32'h0000_3E80, BLK_SZ_S);
		HOST.send_msg(LEN_SHORT_REQ, ID_MUTE_REQ, 16'h0001, 0);
		expect_msg(LEN_ACK, ID_MUTE_ACK, RES_OK);
		check(muted, 1'b1);
		HOST.send_msg(LEN_SHORT_REQ, ID_MUTE_REQ, 16'h0002, 0);
		expect_msg(LEN_ACK, ID_MUTE_ACK, RES_BAD);
		HOST.send_msg(LEN_HOLD_REQ, ID_HOLD_REQ, 16'h0001, 0);
		expect_msg(LEN_ACK, ID_HOLD_ACK, RES_OK);
		expect_msg(LEN_HALTED, ID_HALTED, RES_OK);
		check(output_on, 1'b0);
		HOST.send_msg(LEN_HOLD_REQ, ID_HOLD_REQ, 16'h0000, 0);
		expect_msg(LEN_ACK, ID_HOLD_ACK, RES_OK);
		repeat (4) @(negedge clk);
		check(output_on, 1'b1);
		HOST.send_msg(BLK_HDR + 16'h012C, ID_BLK_REQ, 16'h0000, 0);
		expect_msg(LEN_ACK, ID_BLK_ACK, RES_OK);
		expect_msg(LEN_SPACE, ID_SPACE, RES_OK);
		ticks(556, 812);
		expect_msg(LEN_HALTED, ID_HALTED, RES_OK);
		check(output_on, 1'b0);
		stop_pair(1'b0);
		slow = 1'b1;
		start_stream(32'h0000_AC44, BLK_SZ_M);
		stop_pair(1'b1);
		HOST.send_msg(LEN_SHORT_REQ, 16'h0055, 16'h0000, 0);
		repeat (60) @(negedge clk);
		check(HOST.q_id.size(), 0);
		check(HOST.bad_rsv, 0);
		complete_run();
	end
endmodule
`default_nettype wire
